//--- hbl_host_port.sv
/*
   Host port strobe and address latch logic for an 8-bit data, 15-bit address
   host bus, in two asynchronous modes and one clocked mode.
   Assumes a host on the pins and an internal register file on core_clk that
   returns read data for regAddr in the same cycle, combinationally.
*/
// What this block does
// - Strobe-read mode: drive addressed register data while read strobe is low.
// - Strobe-read mode: release the data bus when the read strobe rises.
// - Data-strobe mode: shared pin acts as the host data strobe.
// - Clocked mode: write when enable, select, read/write low at host clock edge.
// - Strobe-read mode: latch enable pulse starts each cycle and captures address.
// - Latch enable high passes address; falling edge holds it.
// - Address strobe low passes address; rising edge holds it.
// - Clocked mode ignores the address latch pin.
// - Clocked mode samples inputs and updates outputs on host clock rising edges.
`timescale 1ns/1ps
module hbl_host_port
   import hbl_pkg::*;
(
   input  wire logic                          core_clk,
   input  wire logic                          reset_n,
   input  wire hbl_pkg::hbl_pins_type         hostPins,
   output      logic [hbl_pkg::DATA_WIDTH-1:0] hostDataOut,
   output      logic                          hostDataOe,
   output      logic [hbl_pkg::ADDR_WIDTH-1:0] regAddr,
   output      logic                          regWrite,
   output      logic [hbl_pkg::DATA_WIDTH-1:0] regWdata,
   input  wire logic [hbl_pkg::DATA_WIDTH-1:0] regRdata
);
   import hbl_pkg::*;

   hbl_pins_type syncPins;
   hbl_pins_type prevPins;
   hbl_mode_type mode;
   logic         hostClkRise;
   logic         strobeRise;
   logic         rwRise;
   logic         readLoad;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   // The chains rest at idle pin levels; an all-zero reset would read as
   // selected with the read strobe low and drive the bus just after reset.
   hbl_sync #(
      .WIDTH       (PINS_WIDTH),
      .RESET_VALUE (PINS_RESET)
   ) u_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .asyncIn  (hostPins),
      .syncOut  (syncPins)
   );

   // A third copy gives edges without touching the first sync stage.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prevPins <= PINS_RESET;
      end
      else
      begin
         prevPins <= syncPins;
      end
   end

   // Edge detects on synchronised pins.
   assign mode        = hbl_mode_type'(syncPins.mode);
   assign hostClkRise = syncPins.hostClk & ~prevPins.hostClk;
   assign strobeRise  = syncPins.sharedStrobePin & ~prevPins.sharedStrobePin;
   assign rwRise      = syncPins.readWrite_n & ~prevPins.readWrite_n;

   ////////////////////////////////////////////////////////////////////////////
   // Address latch. Pass-through while the latch is open, hold when it closes.
   // The hold is the value seen one core cycle before the closing edge, which
   // the host's address hold time covers at this clock rate.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         regAddr <= ADDR_RESET;
      end
      else
      begin
         unique case (mode)
            MODE_ASYNC_ALE:
            begin
               if (syncPins.addressLatchPin)
               begin
                  regAddr <= syncPins.addr;
               end
            end
            MODE_ASYNC_DS:
            begin
               if (!syncPins.addressLatchPin)
               begin
                  regAddr <= syncPins.addr;
               end
            end
            MODE_CLOCKED:
            begin
               if (hostClkRise)
               begin
                  regAddr <= syncPins.addr;
               end
            end
            default:
            begin
               regAddr <= regAddr;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data drive. In clocked mode the data is loaded one core cycle after
   // the host edge, once the register file has seen the new address.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hostDataOut <= DATA_RESET;
         hostDataOe  <= 1'b0;
         readLoad    <= 1'b0;
      end
      else
      begin
         readLoad <= 1'b0;
         unique case (mode)
            MODE_ASYNC_ALE:
            begin
               hostDataOe  <= !syncPins.chipSelect_n && !syncPins.sharedStrobePin;
               hostDataOut <= regRdata;
            end
            MODE_ASYNC_DS:
            begin
               hostDataOe  <= !syncPins.chipSelect_n && !syncPins.sharedStrobePin
                              && syncPins.readWrite_n;
               hostDataOut <= regRdata;
            end
            MODE_CLOCKED:
            begin
               if (hostClkRise)
               begin
                  hostDataOe <= !syncPins.chipSelect_n && syncPins.readWrite_n;
                  readLoad   <= 1'b1;
               end
               if (readLoad)
               begin
                  hostDataOut <= regRdata;
               end
            end
            default:
            begin
               hostDataOe <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, one core-cycle pulse per host write.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         regWrite <= 1'b0;
         regWdata <= DATA_RESET;
      end
      else
      begin
         regWrite <= 1'b0;
         unique case (mode)
            MODE_ASYNC_ALE:
            begin
               if (rwRise && !syncPins.chipSelect_n)
               begin
                  regWrite <= 1'b1;
                  regWdata <= syncPins.data;
               end
            end
            MODE_ASYNC_DS:
            begin
               if (strobeRise && !syncPins.chipSelect_n && !syncPins.readWrite_n)
               begin
                  regWrite <= 1'b1;
                  regWdata <= syncPins.data;
               end
            end
            MODE_CLOCKED:
            begin
               if (hostClkRise && !syncPins.chipSelect_n && !syncPins.readWrite_n
                   && !syncPins.sharedStrobePin)
               begin
                  regWrite <= 1'b1;
                  regWdata <= syncPins.data;
               end
            end
            default:
            begin
               regWrite <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   property p_read_drive;
      (mode == MODE_ASYNC_ALE) && !syncPins.chipSelect_n && !syncPins.sharedStrobePin
      |=> hostDataOe && (hostDataOut == $past(regRdata));
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read data not driven");

   property p_read_release;
      (mode == MODE_ASYNC_ALE) && syncPins.sharedStrobePin |=> !hostDataOe;
   endproperty
   a_read_release: assert property (p_read_release) else $error("bus not released");

   property p_ds_write;
      (mode == MODE_ASYNC_DS) && strobeRise && !syncPins.chipSelect_n && !syncPins.readWrite_n
      |=> regWrite && (regWdata == $past(syncPins.data)) ##1 !regWrite;
   endproperty
   a_ds_write: assert property (p_ds_write) else $error("data strobe write missing");

   property p_clk_write;
      (mode == MODE_CLOCKED) && hostClkRise && !syncPins.chipSelect_n
      && !syncPins.readWrite_n && !syncPins.sharedStrobePin
      |=> regWrite && (regWdata == $past(syncPins.data));
   endproperty
   a_clk_write: assert property (p_clk_write) else $error("clocked write missing");

   property p_ale_pass;
      (mode == MODE_ASYNC_ALE) && syncPins.addressLatchPin |=> regAddr == $past(syncPins.addr);
   endproperty
   a_ale_pass: assert property (p_ale_pass) else $error("address not captured");

   property p_ale_hold;
      ((mode == MODE_ASYNC_ALE) && !syncPins.addressLatchPin) [*2] |=> $stable(regAddr);
   endproperty
   a_ale_hold: assert property (p_ale_hold) else $error("address not held");

   property p_as_latch;
      (mode == MODE_ASYNC_DS) && !syncPins.addressLatchPin ##1 syncPins.addressLatchPin
      |=> regAddr == $past(syncPins.addr, 2);
   endproperty
   a_as_latch: assert property (p_as_latch) else $error("strobe address wrong");

   property p_clk_ignore_latch;
      (mode == MODE_CLOCKED) && !hostClkRise |=> $stable(regAddr);
   endproperty
   a_clk_ignore_latch: assert property (p_clk_ignore_latch) else $error("address moved");

   property p_clk_data_edge;
      (mode == MODE_CLOCKED) && hostClkRise |=> readLoad ##1 (hostDataOut == $past(regRdata));
   endproperty
   a_clk_data_edge: assert property (p_clk_data_edge) else $error("clocked data late");

   property p_sync_write;
      regWrite && (mode == MODE_ASYNC_ALE)
      |-> $past(syncPins.readWrite_n) && !$past(syncPins.readWrite_n, 2);
   endproperty
   a_sync_write: assert property (p_sync_write) else $error("write not from edge");

endmodule : hbl_host_port

//--- hbl_pkg.sv
/*
   Shared definitions for the host bus strobe and address latch block:
   widths, reset values, the port modes and the bundle of host pins.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package hbl_pkg;

   // Host address and data widths.
   localparam int ADDR_WIDTH = 15;
   localparam int DATA_WIDTH = 8;

   // Values after reset.
   localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 15'h0000;
   localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;

   // Port modes, taken from the mode strap pins.
   typedef enum logic [1:0]
   {
      MODE_ASYNC_ALE = 2'b00,
      MODE_ASYNC_DS  = 2'b01,
      MODE_CLOCKED   = 2'b10
   } hbl_mode_type;

   // All host pins travel together through one synchroniser.
   typedef struct packed
   {
      logic [1:0]            mode;
      logic                  chipSelect_n;
      logic                  readWrite_n;
      logic                  sharedStrobePin;
      logic                  addressLatchPin;
      logic                  hostClk;
      logic [ADDR_WIDTH-1:0] addr;
      logic [DATA_WIDTH-1:0] data;
   } hbl_pins_type;

   localparam int PINS_WIDTH = $bits(hbl_pins_type);

   // Host pins at rest: idle mode, deselected, strobes high, latch closed.
   // Resetting the synchroniser to these levels means release of reset shows
   // no false edge and no bus drive while the chain refills.
   localparam hbl_pins_type PINS_RESET = '{
      mode:            2'h3,
      chipSelect_n:    1'b1,
      readWrite_n:     1'b1,
      sharedStrobePin: 1'b1,
      addressLatchPin: 1'b0,
      hostClk:         1'b0,
      addr:            ADDR_RESET,
      data:            DATA_RESET
   };

endpackage : hbl_pkg

//--- hbl_sync.sv
/*
   Two flip-flop synchroniser, one chain per bit.
   Assumes the inputs are asynchronous to clk and only the second stage is read.
   Both stages reset to RESET_VALUE, which should match the pins' idle levels.
*/
`timescale 1ns/1ps
module hbl_sync #(
   parameter int               WIDTH       = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output      logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] firstStage;

   ////////////////////////////////////////////////////////////////////////////
   // One chain per bit; the first stage feeds nothing but the second.
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      always_ff @(posedge core_clk or negedge reset_n)
      begin
         if (!reset_n)
         begin
            firstStage[i] <= RESET_VALUE[i];
            syncOut[i]    <= RESET_VALUE[i];
         end
         else
         begin
            firstStage[i] <= asyncIn[i];
            syncOut[i]    <= firstStage[i];
         end
      end
   end

endmodule : hbl_sync

//--- hbl_host_model.sv
/*
   Host processor model that drives the host pins of the port.
   Assumes one bench process calls its tasks, one at a time.
*/
`timescale 1ns/1ps
module hbl_host_model
(
   input  wire logic                  core_clk,
   output      hbl_pkg::hbl_pins_type pins
);
   import hbl_pkg::*;

   // Idle host: deselected, strobes high, bus clock low.
   initial pins = '{mode: MODE_ASYNC_ALE, chipSelect_n: 1'b1, readWrite_n: 1'b1, sharedStrobePin: 1'b1,
                    addressLatchPin: 1'b0, hostClk: 1'b0, addr: '0, data: '0};

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask : step

   ////////////////////////////////////////////////////////////////////////////
   // The latch pin rests closed, so a mode change never opens the address path.
   task automatic set_mode(input hbl_mode_type m);
      @(posedge core_clk);
      pins.mode            <= m;
      pins.addressLatchPin <= (m == MODE_ASYNC_DS);
   endtask : set_mode

   // latch pulse first
   // The address bus turns to its inverse once the latch closes, so a leaky latch shows.
   task automatic latch(input logic [14:0] a);
      @(posedge core_clk);
      pins.addr            <= a;
      pins.addressLatchPin <= (pins.mode == MODE_ASYNC_ALE);
      step(3);
      pins.addressLatchPin <= (pins.mode != MODE_ASYNC_ALE);
      step(2);
      pins.addr            <= ~a;
   endtask : latch

   task automatic read_on(input logic csN);
      @(posedge core_clk);
      pins.chipSelect_n    <= csN;
      pins.readWrite_n     <= 1'b1;
      pins.sharedStrobePin <= 1'b0;
   endtask : read_on

   task automatic read_off();
      @(posedge core_clk);
      pins.chipSelect_n    <= 1'b1;
      pins.sharedStrobePin <= 1'b1;
   endtask : read_off

   // The write strobe is readWrite_n in latch mode and the data strobe otherwise.
   task automatic write(input logic [7:0] d);
      @(posedge core_clk);
      pins.chipSelect_n    <= 1'b0;
      pins.readWrite_n     <= 1'b0;
      pins.data            <= d;
      pins.sharedStrobePin <= (pins.mode == MODE_ASYNC_ALE);
      step(4);
      pins.readWrite_n     <= (pins.mode == MODE_ASYNC_ALE);
      pins.sharedStrobePin <= 1'b1;
      step(4);
      pins.chipSelect_n    <= 1'b1;
      pins.readWrite_n     <= 1'b1;
      pins.data            <= ~d;
   endtask : write

   // inputs other than the latch pin steady across the rise
   // Bus clock is high four core cycles and low at least five, slower than the 33 MHz ceiling.
   task automatic pclk(input logic csN, rw, we, input logic [14:0] a, input logic [7:0] d);
      @(posedge core_clk);
      pins.chipSelect_n    <= csN;
      pins.readWrite_n     <= rw;
      pins.sharedStrobePin <= we;
      pins.addr            <= a;
      pins.data            <= d;
      pins.addressLatchPin <= 1'($urandom);
      step(4);
      pins.hostClk         <= 1'b1;
      pins.addressLatchPin <= 1'($urandom);
      step(4);
      pins.hostClk         <= 1'b0;
   endtask : pclk
endmodule : hbl_host_model

//--- tb.sv
/*
   Self-checking bench for the host port in all three modes.
   Assumes the host model file and a register file mimicked here.
*/
`timescale 1ns/1ps
module tb;
   import hbl_pkg::*;

   logic                  core_clk;
   logic                  reset_n;
   hbl_pins_type          hostPins;
   logic [DATA_WIDTH-1:0] hostDataOut;
   logic [DATA_WIDTH-1:0] regWdata;
   logic [DATA_WIDTH-1:0] regRdata;
   logic [DATA_WIDTH-1:0] wrData;
   logic [DATA_WIDTH-1:0] d;
   logic [ADDR_WIDTH-1:0] regAddr;
   logic [ADDR_WIDTH-1:0] wrAddr;
   logic [ADDR_WIDTH-1:0] a;
   logic                  hostDataOe;
   logic                  regWrite;
   logic                  csN;
   logic                  rw;
   logic                  we;
   int                    err_count;
   int                    tests_run;
   int                    wrCount;
   int                    cycles;
   int                    n;
   int                    seed;

   // Register file contents as a pure function of the address.
   function automatic logic [7:0] rd_of(input logic [14:0] x);
      return x[7:0] ^ {1'b0, x[14:8]} ^ 8'ha5;
   endfunction : rd_of

   assign regRdata = rd_of(regAddr);

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   hbl_host_model host_u (.core_clk(core_clk), .pins(hostPins));

   hbl_host_port dut_u (.core_clk(core_clk), .reset_n(reset_n), .hostPins(hostPins), .hostDataOut(hostDataOut),
                        .hostDataOe(hostDataOe), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
                        .regRdata(regRdata));

   ////////////////////////////////////////////////////////////////////////////
   // Write monitor and hang guard; the run needs well under a thousand cycles.
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (regWrite === 1'b1)
      begin
         wrCount <= wrCount + 1;
         wrData  <= regWdata;
         wrAddr  <= regAddr;
      end
      if (cycles == 5000)
      begin
         err_count++;
         close_out();
      end
   end

   task automatic close_out();
      if (err_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [23:0] exp, got);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Waits past the edge so its updates have landed before sampling.
   task automatic settle(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////
   // Both asynchronous modes with boundary addresses first, then the clocked mode.
   initial
   begin
      reset_n   = 1'b0;
      err_count = 0;
      tests_run = 0;
      wrCount   = 0;
      cycles    = 0;
      seed      = $urandom(20746);
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      // Just after release the chain still holds its reset levels: no drive, no write.
      settle(1);
      check("hostDataOe", 24'(0), 24'(hostDataOe));
      check("regWrite", 24'(0), 24'(regWrite));
      settle(2);
      for (int m = 0; m < 2; m++)
      begin
         host_u.set_mode(hbl_mode_type'(m));
         settle(6);
         for (int i = 0; i < 8; i++)
         begin
            a   = (i == 0) ? 15'h7fff : (i == 1) ? 15'h0000 : 15'($urandom);
            d   = 8'($urandom);
            csN = (i < 2) ? 1'b0 : 1'($urandom);
            n   = wrCount;
            host_u.latch(a);
            host_u.read_on(csN);
            settle(5);
            check("regAddr", 24'(a), 24'(regAddr));
            check("hostDataOe", 24'(!csN), 24'(hostDataOe));
            if (!csN)
               check("hostDataOut", 24'(rd_of(a)), 24'(hostDataOut));
            host_u.read_off();
            settle(5);
            check("hostDataOe", 24'(0), 24'(hostDataOe));
            host_u.write(d);
            settle(1);
            check("wrCount", 24'(n + 1), 24'(wrCount));
            check("wrAddrData", {1'b0, a, d}, {1'b0, wrAddr, wrData});
         end
      end
      host_u.set_mode(MODE_CLOCKED);
      settle(6);
      for (int i = 0; i < 10; i++)
      begin
         a   = 15'($urandom);
         d   = 8'($urandom);
         csN = (i < 2) ? 1'b0 : 1'($urandom);
         rw  = (i < 2) ? i[0] : 1'($urandom);
         we  = (i < 2) ? 1'b0 : 1'($urandom);
         n   = wrCount;
         host_u.pclk(csN, rw, we, a, d);
         settle(1);
         check("regAddr", 24'(a), 24'(regAddr));
         check("hostDataOe", 24'(!csN && rw), 24'(hostDataOe));
         if (!csN && rw)
            check("hostDataOut", 24'(rd_of(a)), 24'(hostDataOut));
         check("wrCount", 24'(n + !(csN | rw | we)), 24'(wrCount));
         if (!(csN | rw | we))
            check("wrData", 24'(d), 24'(wrData));
      end
      // Mode code 11 is idle: a full read and a full write must neither drive nor write.
      host_u.set_mode(hbl_mode_type'(2'h3));
      settle(6);
      n = wrCount;
      host_u.read_on(1'b0);
      settle(5);
      check("hostDataOe", 24'(0), 24'(hostDataOe));
      host_u.read_off();
      host_u.write(d);
      settle(1);
      check("wrCount", 24'(n), 24'(wrCount));
      close_out();
   end
endmodule : tb
